// ---- rtl/cmam_top.sv ----
// CPU memory address mapper: logical-to-physical translation, board select, legacy strobe
`timescale 1ns/1ns
module cmam_top
  import cmam_pkg::*;
(
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  input  wire logic                    i_cpu_req,
  input  wire logic [CMAM_LOG_AW-1:0]  i_cpu_addr,
  input  wire logic                    i_map_we,
  input  wire logic [CMAM_IDX_W-1:0]   i_map_idx,
  input  wire logic [CMAM_BLK_W-1:0]   i_map_blk,
  input  wire logic [CMAM_SW_W-1:0]    i_base_sw_down,
  input  wire logic                    i_master_mode,
  input  wire logic                    i_legacy_strobe_clock_jumper,
  input  wire logic                    i_clk_phase,
  input  wire logic [CMAM_PHYS_AW-1:0] i_bus_addr,
  output logic      [CMAM_PHYS_AW-1:0] o_bus_addr,
  output logic                         o_bus_addr_vld,
  output logic                         o_board_sel,
  output logic                         o_stval_n,
  output logic                         o_stval_oe
);

  // ************************************************
  // Pin synchronisers
  // ************************************************
  logic [CMAM_SW_W-1:0] sw_m_q, sw_s_q;
  logic                 mst_m_q, mst_s_q, leg_m_q, leg_s_q, ph_m_q, ph_s_q;
  logic [CMAM_PHYS_AW-1:0] ba_m_q, ba_s_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sw_m_q  <= '0;
      sw_s_q  <= '0;
      mst_m_q <= 1'b0;
      mst_s_q <= 1'b0;
      leg_m_q <= 1'b0;
      leg_s_q <= 1'b0;
      ph_m_q  <= 1'b0;
      ph_s_q  <= 1'b0;
      ba_m_q  <= '0;
      ba_s_q  <= '0;
    end else if (i_ce) begin
      sw_m_q  <= i_base_sw_down;
      sw_s_q  <= sw_m_q;
      mst_m_q <= i_master_mode;
      mst_s_q <= mst_m_q;
      leg_m_q <= i_legacy_strobe_clock_jumper;
      leg_s_q <= leg_m_q;
      ph_m_q  <= i_clk_phase;
      ph_s_q  <= ph_m_q;
      ba_m_q  <= i_bus_addr;
      ba_s_q  <= ba_m_q;
    end
  end

  // ************************************************
  // Translation
  // ************************************************
  logic [CMAM_BLK_W-1:0] blk;
  logic [CMAM_OFS_W-1:0] ofs_q, ofs_d;
  logic                  req_q, req_d;

  // Index comes straight from the CPU so lookup and offset line up one cycle later
  cmam_map_mem #(
    .IDX_W (CMAM_IDX_W),
    .DW    (CMAM_BLK_W)
  ) u_map (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_we      (i_map_we),
    .i_waddr   (i_map_idx),
    .i_wdata   (i_map_blk),
    .i_raddr   (i_cpu_addr[CMAM_LOG_AW-1 -: CMAM_IDX_W]),
    .o_rdata   (blk)
  );

  always_comb begin
    ofs_d = i_cpu_addr[CMAM_OFS_W-1:0];
    req_d = i_cpu_req;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ofs_q <= '0;
      req_q <= 1'b0;
    end else if (i_ce) begin
      ofs_q <= ofs_d;
      req_q <= req_d;
    end
  end

  // Physical address is base block concatenated with offset: base always a 4K multiple
  logic [CMAM_PHYS_AW-1:0] addr_q, addr_d;
  logic                    vld_q, vld_d;

  always_comb begin
    addr_d = addr_q;
    vld_d  = req_q;
    if (req_q) begin
      addr_d = {blk, ofs_q};
    end
  end

  // Fixed pipeline latency for every access, extended or not: no extra cycles
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      addr_q <= '0;
      vld_q  <= 1'b0;
    end else if (i_ce) begin
      addr_q <= addr_d;
      vld_q  <= vld_d;
    end
  end

  // Only the address lines are driven; no board's own decode is touched
  assign o_bus_addr     = addr_q;
  assign o_bus_addr_vld = vld_q;

  // ************************************************
  // Board base select
  // ************************************************
  logic sel_q, sel_d;
  logic [CMAM_SW_W-1:0] hit;

  // Switch bit k (k=0 is leftmost) is compared with address line A16+k; down reads 1
  generate
    for (genvar k = 0; k < CMAM_SW_W; k++) begin : g_sw
      assign hit[k] = (sw_s_q[k] == ba_s_q[CMAM_SW_LSB + k]);
    end
  endgenerate

  always_comb begin
    // Master ignores A16 so it claims a 128K block
    if (mst_s_q) begin
      sel_d = &hit[CMAM_SW_W-1:CMAM_MST_LSB-CMAM_SW_LSB];
    end else begin
      sel_d = &hit;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sel_q <= 1'b0;
    end else if (i_ce) begin
      sel_q <= sel_d;
    end
  end

  assign o_board_sel = sel_q;

  // ************************************************
  // Legacy status-valid strobe
  // ************************************************
  logic stv_q, stv_d, oe_q, oe_d;

  always_comb begin
    oe_d  = leg_s_q;
    stv_d = leg_s_q ? ph_s_q : 1'b1;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stv_q <= 1'b1;
      oe_q  <= 1'b0;
    end else if (i_ce) begin
      stv_q <= stv_d;
      oe_q  <= oe_d;
    end
  end

  assign o_stval_n  = stv_q;
  assign o_stval_oe = oe_q;
endmodule

// ---- shared/cmam_pkg.sv ----
// Constants and types shared by the CPU memory address mapper
//
// What this block does
// - The CPU's 64K logical view can be placed anywhere in physical memory in 4K steps.
// - Logical address zero always lands on a 4K multiple, as does each other 4K logical block.
// - Every memory access drives a true 24-bit physical address onto the bus lines.
// - The mapper never changes how any board decodes its own address.
// - Extended translation adds no cycle or visible effect to the CPU or other bus agents.
// - The mapping may be rewritten between any two memory accesses.
// - An eight-position switch picks the board's 128K block as master or 64K block as slave.
// - As slave the eight switches are compared with the top eight bits of the 24-bit bus address; as master A16 is not compared.
// - A switch up reads as logic 0 and a switch down reads as logic 1.
// - The leftmost switch is the lowest compared bit, address line A16, the rest ascending.
// - In legacy mode the system clock phase is routed to the bus status-valid strobe.
// - Each of the sixteen 4096-byte logical blocks is mapped on its own.
// - Mapped blocks may be scattered, and several logical blocks may share one physical block.
package cmam_pkg;
  localparam int CMAM_LOG_AW   = 16;
  localparam int CMAM_PHYS_AW  = 24;
  localparam int CMAM_OFS_W    = 12;
  localparam int CMAM_IDX_W    = 4;
  localparam int CMAM_BLK_W    = 12;
  localparam int CMAM_ENTRIES  = 16;
  localparam int CMAM_SW_W     = 8;
  localparam int CMAM_SW_LSB   = 16;
  localparam int CMAM_SW_MSB   = 23;
  // Master compares A23..A17 (128K block), slave compares A23..A16 (64K block)
  localparam int CMAM_MST_LSB  = 17;
  // Reset map: logical block n points at physical block n (boot ROM lives at the bottom)
  localparam logic [CMAM_BLK_W-1:0] CMAM_RST_BASE = 12'h000;
endpackage

// ---- rtl/cmam_map_mem.sv ----
// Sixteen-entry translation table with registered read
`timescale 1ns/1ns
module cmam_map_mem
  import cmam_pkg::*;
#(
  parameter int IDX_W = CMAM_IDX_W,
  parameter int DW    = CMAM_BLK_W
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_we,
  input  wire logic [IDX_W-1:0] i_waddr,
  input  wire logic [DW-1:0]    i_wdata,
  input  wire logic [IDX_W-1:0] i_raddr,
  output logic      [DW-1:0]    o_rdata
);
  localparam int N = 1 << IDX_W;

  logic [DW-1:0] mem_q [N];
  logic [DW-1:0] mem_d [N];
  logic [DW-1:0] rdata_d;

  // ************************************************
  // Table update and read
  // ************************************************
  always_comb begin
    mem_d = mem_q;
    if (i_we) begin
      mem_d[i_waddr] = i_wdata;
    end
    // Write-through so a map change takes effect on an access issued in the same cycle as the write
    if (i_we && (i_waddr == i_raddr)) begin
      rdata_d = i_wdata;
    end else begin
      rdata_d = mem_q[i_raddr];
    end
  end

  // Reset identity map, entries are independent and may repeat
  generate
    for (genvar g = 0; g < N; g++) begin : g_ent
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          mem_q[g] <= CMAM_RST_BASE + DW'(g);
        end else if (i_ce) begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= CMAM_RST_BASE;
    end else if (i_ce) begin
      o_rdata <= rdata_d;
    end
  end
endmodule

// ---- verif/cmam_assertions.sv ----
// Port checks for the address mapper
`timescale 1ns/1ns
module cmam_assertions (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_cpu_req,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [7:0]  i_base_sw_down,
  input wire logic        i_master_mode,
  input wire logic        i_legacy_strobe_clock_jumper,
  input wire logic        i_clk_phase,
  input wire logic [23:0] i_bus_addr,
  input wire logic [23:0] o_bus_addr,
  input wire logic        o_bus_addr_vld,
  input wire logic        o_board_sel,
  input wire logic        o_stval_n,
  input wire logic        o_stval_oe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire logic jmp = i_legacy_strobe_clock_jumper;
  chk_req_vld: assert property (i_ce && i_cpu_req ##1 i_ce |=> o_bus_addr_vld)
    else $error("no valid after request");
  chk_idle_vld: assert property (i_ce && !i_cpu_req ##1 i_ce |=> !o_bus_addr_vld)
    else $error("valid without request");
  chk_ofs_pass: assert property (i_ce && i_cpu_req ##1 i_ce |=> o_bus_addr[11:0] == $past(i_cpu_addr[11:0], 2))
    else $error("offset not passed through");
  chk_addr_hold: assert property (!o_bus_addr_vld |-> $stable(o_bus_addr))
    else $error("address moved without valid");
  chk_stb_off: assert property ((i_ce && !jmp)[*4] |-> o_stval_n && !o_stval_oe)
    else $error("strobe driven outside legacy mode");
  chk_stb_on: assert property ((i_ce && jmp)[*4] |-> o_stval_oe && o_stval_n == $past(i_clk_phase, 3))
    else $error("strobe not following phase");
  chk_sel_slave: assert property ((i_ce && !i_master_mode && $stable(i_bus_addr) && $stable(i_base_sw_down))[*4]
    |-> o_board_sel == (i_bus_addr[23:16] == i_base_sw_down)) else $error("slave select wrong");
  chk_sel_master: assert property ((i_ce && i_master_mode && $stable(i_bus_addr) && $stable(i_base_sw_down))[*4]
    |-> o_board_sel == (i_bus_addr[23:17] == i_base_sw_down[7:1])) else $error("master select wrong");
endmodule
bind cmam_top cmam_assertions u_chk (.*);

// ---- verif/cmam_bus_agent.sv ----
// Far-side bus agent that places addresses on the bus
`timescale 1ns/1ns
module cmam_bus_agent (
  input  wire logic        i_clk_sys,
  input  wire logic        i_en,
  input  wire logic [23:0] i_addr,
  output logic      [23:0] o_bus
);
  // Released lines flip every cycle so a stale value is never mistaken for a drive
  always_ff @(posedge i_clk_sys) o_bus <= i_en ? i_addr : ~o_bus;
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the address mapper
`timescale 1ns/1ns
module tb_top;
  logic        clk = 0, rst = 1, req = 0, we = 0, mst = 0, jmp = 0, ph = 0, ce = 1;
  logic [15:0] a = 0;
  logic [3:0]  ix = 0;
  logic [11:0] bk = 0, em [16];
  logic [7:0]  sw = 0;
  logic [23:0] ba = 0, bus, oa, q [$];
  logic        vld, sel, stval_n, soe;
  int          bad_count = 0, comparisons = 0;
  cmam_top dut (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_cpu_req(req), .i_cpu_addr(a),
    .i_map_we(we), .i_map_idx(ix), .i_map_blk(bk), .i_base_sw_down(sw), .i_master_mode(mst),
    .i_legacy_strobe_clock_jumper(jmp), .i_clk_phase(ph), .i_bus_addr(bus), .o_bus_addr(oa),
    .o_bus_addr_vld(vld), .o_board_sel(sel), .o_stval_n(stval_n), .o_stval_oe(soe));
  cmam_bus_agent agent (.i_clk_sys(clk), .i_en(1'b1), .i_addr(ba), .o_bus(bus));
  initial forever #50 clk = ~clk;
  initial begin
    #2000000;
    bad_count++;
    tally_and_finish;
  end
  task automatic tally_and_finish;
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(logic [23:0] s, logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask
  // Answers come back in request order; looked at mid-cycle so the launching edge never races
  always @(negedge clk) if (vld === 1'b1) check(oa, q.pop_front());
  task automatic cyc(logic r, logic [15:0] ad, logic w, logic [3:0] i, logic [11:0] b);
    @(posedge clk);
    req <= r;
    a <= ad;
    we <= w;
    ix <= i;
    bk <= b;
    if (w) em[i] = b;
    if (r) q.push_back({em[ad[15:12]], ad[11:0]});
  endtask
  task automatic drain;
    repeat (4) cyc(0, 0, 0, 0, 0);
    check(24'(q.size()), 0);
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst <= 1;
    repeat (16) @(posedge clk);
    check(24'({vld, sel, soe, stval_n}), 24'h1);
    rst <= 0;
    for (int n = 0; n < 16; n++) em[n] = 12'(n);
  endtask
  task automatic t_boot;
    for (int n = 0; n < 16; n++) cyc(1, {n[3:0], {12{n[0]}}}, 0, 0, 0);
    drain;
  endtask
  task automatic t_remap;
    cyc(0, 0, 1, 4'h0, 12'hFFF);
    cyc(0, 0, 1, 4'h1, 12'hFFF);
    cyc(1, 16'h0ABC, 1, 4'hF, 12'h800);
    cyc(1, 16'h1123, 0, 0, 0);
    cyc(1, 16'hF001, 1, 4'h3, 12'h05F);
    cyc(1, 16'h3FFF, 1, 4'h3, 12'h040);
    drain;
  endtask
  // Clock enable low must freeze the pipeline; the request is only taken once it returns
  task automatic t_stall;
    @(posedge clk);
    ce <= 0;
    req <= 1;
    a <= 16'h2345;
    we <= 0;
    q.push_back({em[4'h2], 12'h345});
    repeat (4) @(posedge clk);
    #1 check(24'(vld), 24'h0);
    ce <= 1;
    @(posedge clk);
    req <= 0;
    drain;
  endtask
  task automatic sel_case(logic m, logic [7:0] s, logic [23:0] b, logic e);
    @(posedge clk);
    mst <= m;
    sw <= s;
    ba <= b;
    repeat (6) @(posedge clk);
    #1 check(24'(sel), 24'(e));
  endtask
  task automatic t_sel;
    for (int i = 0; i < 8; i++) begin
      sel_case(0, 8'h01 << i, 24'h010000 << i, 1);
      sel_case(0, 8'h01 << i, 24'h000000, 0);
    end
    sel_case(1, 8'h01, 24'h000000, 1);
    sel_case(0, 8'hA4, 24'hA5FFFF, 0);
    sel_case(1, 8'hA4, 24'hA5FFFF, 1);
    sel_case(1, 8'hA4, 24'h25FFFF, 0);
  endtask
  task automatic stb_case(logic j, logic p, logic [1:0] e);
    @(posedge clk);
    jmp <= j;
    ph <= p;
    repeat (5) @(posedge clk);
    #1 check(24'({soe, stval_n}), 24'(e));
  endtask
  initial begin
    t_reset;
    t_boot;
    t_remap;
    t_stall;
    t_sel;
    stb_case(1, 0, 2'b10);
    stb_case(1, 1, 2'b11);
    stb_case(0, 0, 2'b01);
    t_reset;
    t_boot;
    tally_and_finish;
  end
endmodule
